// ---- pkg/mon_pkg.sv ----
/*
  Shared constants and carrier types of the monitor serial command block.
  Assumes one bus clock; all serial timing is counted in bus cycles.
*/
package mon_pkg;
  localparam int BUS_PER_BIT = 256;
  localparam int FRAME_BITS = 10;
  localparam int GAP_BITS = 2;
  localparam int BRK_HIGH_BITS = 2;
  localparam int END_DELAY_BITS = 11;
  localparam int SEC_BYTES = 8;
  localparam logic [15:0] SEC_BASE = 16'hfff6;
  localparam logic [15:0] SEC_FLAG_ADDR = 16'h0040;
  localparam logic [7:0] SEC_FLAG_MASK = 8'h40;
  localparam logic [7:0] USER_PAGE = 8'hff;
  localparam logic [7:0] MON_PAGE = 8'hfe;
  localparam logic [7:0] RESET_VEC_LO = 8'hfe;
  localparam logic [7:0] INT_VEC_LO = 8'hfc;
  localparam logic [7:0] OP_READ = 8'h4a;
  localparam logic [7:0] OP_WRITE = 8'h51;
  localparam logic [7:0] OP_INDEXED_READ_CMD = 8'h52;
  localparam logic [7:0] OP_INDEXED_WRITE_CMD = 8'h53;
  localparam logic [7:0] OP_STACK_POINTER_READ_CMD = 8'h54;
  localparam logic [7:0] OP_RUN = 8'h55;
  localparam logic [3:0] SYNC_RST = 4'h8;
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_s;
  typedef struct packed {
    logic monitor;
    logic forced;
    logic hv;
    logic div4;
  } mode_s;
endpackage : mon_pkg

// ---- src/monitor_serial_command_interface.sv ----
/*
  Monitor-mode serial command interpreter: entry options, vector page,
  single-wire echoing link, memory commands and the security check.
  Assumes a memory port answering one cycle after MEM_VALID, a stack
  pointer from the CPU on this clock, and a pull-up on the serial wire.
*/
// Functional notes
// - Watchdog off while high voltage stays applied
// - Forced entry ignores divider-select pin
// - Forced entry divides external clock by four
// - Forced entry always disables watchdog
// - Monitor mode uses alternate vector page
// - NRZ format, same rate both ways
// - Break: drive high two bits, echo
// - Bit time is 256 bus cycles
// - Divider pin sampled only with high voltage
// - Every byte received outside the end delay is echoed
// - Eleven-bit end delay, break cancels
// - Two-bit gap before echo and data
// - Read data follows last echo
// - Read: opcode, address high, low
// - Entry interrupts; run pops and returns
// - Stack read returns pointer plus one
// - Eight security bytes compared after power-on
// - Bypass survives non-power-on resets
// - Mismatch: invalid flash data, illegal run
// - Break sent after all security bytes
// - Pass sets bit six at 40
`timescale 1ns/1ps
module monitor_serial_command_interface import mon_pkg::*; #(
  parameter int BIT_CYCLES = BUS_PER_BIT,
  parameter logic [15:0] FLASH_START = 16'hc000,
  parameter logic [7:0] INVALID_BYTE = 8'had
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic POR_RST_B,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  output logic SERIAL_OE,
  input wire logic HV_ON_IRQ,
  input wire logic HV_ON_RST,
  input wire logic DIVIDER_SELECT_PIN,
  input wire logic VECTOR_BLANK,
  input wire logic [15:0] STACK_PTR,
  input wire logic [7:0] MEM_RDATA,
  output logic MEM_VALID,
  output mem_req_s MEM,
  output logic MONITOR_MODE,
  output logic WATCHDOG_DISABLE,
  output logic EXT_DIV4,
  output logic [7:0] VEC_PAGE,
  output logic SWI_ENTRY,
  output logic RUN_USER,
  output logic ILLEGAL_RESET,
  output logic FLASH_UNLOCKED
);
  localparam int CW = $clog2(BIT_CYCLES);

  if (BIT_CYCLES < 8 || BIT_CYCLES > 4096) begin : g_chk
    $error("BIT_CYCLES out of range");
  end

  typedef enum logic [3:0] {
    ST_ENTRY, ST_USER, ST_RX, ST_NEXT, ST_CHK, ST_MEM, ST_MEMW,
    ST_GAP, ST_TX, ST_BRKHI, ST_SPLO, ST_DELAY
  } state_e;

  function automatic logic [1:0] op_len(input logic [7:0] o);
    case (o)
      OP_READ: op_len = 2'd2;
      OP_WRITE: op_len = 2'd3;
      OP_INDEXED_WRITE_CMD: op_len = 2'd1;
      default: op_len = 2'd0;
    endcase
  endfunction : op_len

  state_e st, st_prev, after;
  mode_s mode;
  logic [3:0] s1, s2;
  logic [CW-1:0] cyc, cur, rx_cnt;
  logic [3:0] nb, nbe, rx_n, sec_cnt;
  logic [9:0] rx_sh, frame;
  logic rx_on, rx_done, moved, tick, listen;
  logic end_tx, end_gap, end_brk, end_dly;
  logic [1:0] ent, idx;
  logic [7:0] op, tx_byte;
  logic [15:0] addr, sp1;
  logic tx_brk, phase_sec, match, sec_pass, is_wr, locked_rd;

  wire line = s2[3];
  wire hv_irq = s2[2];
  wire hv_rst = s2[1];
  wire div_pin = s2[0];
  wire rx_brk = rx_sh == 10'h000;
  wire [7:0] rx_data = rx_sh[8:1];

  // Bit timer restarts on every state change so each span is whole bits
  assign moved = st != st_prev;
  assign cur = moved ? '0 : cyc;
  assign nbe = moved ? 4'h0 : nb;
  assign tick = cur == CW'(BIT_CYCLES - 1);
  assign end_tx = tick && nbe == 4'(FRAME_BITS - 1);
  assign end_gap = tick && nbe == 4'(GAP_BITS - 1);
  assign end_brk = tick && nbe == 4'(BRK_HIGH_BITS - 1);
  assign end_dly = tick && nbe == 4'(END_DELAY_BITS - 1);
  assign listen = st == ST_RX || st == ST_DELAY;
  assign frame = tx_brk ? 10'h000 : {1'b1, tx_byte, 1'b0};
  assign is_wr = op == OP_WRITE || op == OP_INDEXED_WRITE_CMD;
  assign sp1 = STACK_PTR + 16'h0001;
  assign locked_rd = !FLASH_UNLOCKED && MEM.addr >= FLASH_START;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      s1 <= SYNC_RST;
      s2 <= SYNC_RST;
      cyc <= '0;
      nb <= 4'h0;
      st_prev <= ST_ENTRY;
    end else begin
      s1 <= {SERIAL_IN, HV_ON_IRQ, HV_ON_RST, DIVIDER_SELECT_PIN};
      s2 <= s1;
      cyc <= tick ? '0 : cur + 1'b1;
      nb <= nbe + {3'h0, tick};
      st_prev <= st;
    end
  end

  // mid-bit sampling at the shared rate
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rx_on <= 1'b0;
      rx_cnt <= '0;
      rx_n <= 4'h0;
      rx_sh <= 10'h3ff;
      rx_done <= 1'b0;
    end else begin
      rx_done <= rx_on && rx_cnt == '0 && rx_n == 4'h9;
      if (!rx_on) begin
        rx_on <= listen && !line;
        rx_cnt <= CW'(BIT_CYCLES / 2);
        rx_n <= 4'h0;
      end else if (rx_cnt == '0) begin
        rx_sh <= {line, rx_sh[9:1]};
        rx_n <= rx_n + 4'h1;
        rx_cnt <= CW'(BIT_CYCLES - 1);
        // A start bit gone by mid-bit is dropped: our own break tail looks like one
        rx_on <= rx_n != 4'h9 && !(rx_n == 4'h0 && line);
      end else begin
        rx_cnt <= rx_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      SERIAL_OUT <= 1'b1;
      SERIAL_OE <= 1'b0;
      MONITOR_MODE <= 1'b0;
      WATCHDOG_DISABLE <= 1'b0;
      EXT_DIV4 <= 1'b0;
      VEC_PAGE <= USER_PAGE;
    end else begin
      SERIAL_OE <= st == ST_TX || st == ST_BRKHI;
      SERIAL_OUT <= st == ST_TX ? frame[nbe] : 1'b1;
      MONITOR_MODE <= mode.monitor;
      WATCHDOG_DISABLE <= mode.forced || (mode.hv && (hv_irq || hv_rst));
      EXT_DIV4 <= mode.forced || mode.div4;
      VEC_PAGE <= mode.monitor ? MON_PAGE : USER_PAGE;
    end
  end

  always_ff @(posedge CLOCK or negedge POR_RST_B) begin
    if (!POR_RST_B) begin
      FLASH_UNLOCKED <= 1'b0;
    end else if (sec_pass) begin
      FLASH_UNLOCKED <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      st <= ST_ENTRY;
      after <= ST_RX;
      mode <= '0;
      ent <= 2'd0;
      idx <= 2'd0;
      op <= 8'h00;
      tx_byte <= 8'h00;
      tx_brk <= 1'b0;
      addr <= 16'h0000;
      phase_sec <= 1'b0;
      match <= 1'b1;
      sec_cnt <= 4'h0;
      sec_pass <= 1'b0;
      MEM <= '0;
      MEM_VALID <= 1'b0;
      SWI_ENTRY <= 1'b0;
      RUN_USER <= 1'b0;
      ILLEGAL_RESET <= 1'b0;
    end else begin
      MEM_VALID <= 1'b0;
      SWI_ENTRY <= 1'b0;
      RUN_USER <= 1'b0;
      ILLEGAL_RESET <= 1'b0;
      sec_pass <= 1'b0;
      unique case (st)
        ST_ENTRY: begin
          ent <= ent + 2'd1;
          if (ent == 2'd3) begin
            // divider pin only with high voltage
            mode <= '{monitor: hv_irq || VECTOR_BLANK, forced: !hv_irq && VECTOR_BLANK,
                      hv: hv_irq, div4: hv_irq && div_pin};
            SWI_ENTRY <= hv_irq || VECTOR_BLANK;
            // security bytes only when still locked
            phase_sec <= !FLASH_UNLOCKED;
            st <= (hv_irq || VECTOR_BLANK) ? ST_RX : ST_USER;
          end
        end
        ST_USER: st <= ST_USER;
        ST_RX: begin
          if (rx_done && rx_brk) begin
            st <= ST_BRKHI;
          end else if (rx_done) begin
            tx_byte <= rx_data;
            tx_brk <= 1'b0;
            after <= ST_NEXT;
            st <= ST_GAP;
          end
        end
        ST_NEXT: begin
          if (phase_sec) begin
            MEM <= '{we: 1'b0, addr: SEC_BASE + {12'h000, sec_cnt}, wdata: 8'h00};
            MEM_VALID <= 1'b1;
            st <= ST_MEM;
          end else begin
            if (idx == 2'd0) begin
              op <= tx_byte;
            end else if (is_wr && idx == op_len(op)) begin
              MEM.wdata <= tx_byte;
            end else begin
              addr <= {addr[7:0], tx_byte};
            end
            st <= ST_CHK;
          end
        end
        ST_CHK: begin
          if (idx != op_len(op)) begin
            idx <= idx + 2'd1;
            st <= ST_RX;
          end else if (op == OP_READ || op == OP_INDEXED_READ_CMD || is_wr) begin
            MEM.we <= is_wr;
            MEM.addr <= addr;
            MEM_VALID <= 1'b1;
            if (op == OP_INDEXED_READ_CMD || op == OP_INDEXED_WRITE_CMD) begin
              addr <= addr + 16'h0001;
            end
            st <= ST_MEM;
          end else if (op == OP_STACK_POINTER_READ_CMD) begin
            // pointer plus one, high byte first
            tx_byte <= sp1[15:8];
            tx_brk <= 1'b0;
            after <= ST_SPLO;
            st <= ST_GAP;
          end else if (op == OP_RUN) begin
            // pop and return, illegal while locked
            RUN_USER <= 1'b1;
            ILLEGAL_RESET <= !FLASH_UNLOCKED;
            st <= ST_DELAY;
          end else begin
            st <= ST_DELAY;
          end
        end
        ST_MEM: st <= ST_MEMW;
        ST_MEMW: begin
          if (phase_sec && !MEM.we) begin
            // compare each byte against its stored copy
            match <= match && MEM_RDATA == tx_byte;
            sec_cnt <= sec_cnt + 4'h1;
            if (sec_cnt != 4'(SEC_BYTES - 1)) begin
              st <= ST_RX;
            end else if (match && MEM_RDATA == tx_byte) begin
              sec_pass <= 1'b1;
              // flag byte; other bits of it are not kept
              MEM <= '{we: 1'b1, addr: SEC_FLAG_ADDR, wdata: SEC_FLAG_MASK};
              MEM_VALID <= 1'b1;
              st <= ST_MEM;
            end else begin
              tx_brk <= 1'b1;
              after <= ST_RX;
              phase_sec <= 1'b0;
              st <= ST_TX;
            end
          end else if (phase_sec) begin
            // ready break after the last security byte
            tx_brk <= 1'b1;
            after <= ST_RX;
            phase_sec <= 1'b0;
            st <= ST_TX;
          end else if (MEM.we) begin
            st <= ST_DELAY;
          end else begin
            // data after last echo, flash addresses masked while locked
            tx_byte <= locked_rd ? INVALID_BYTE : MEM_RDATA;
            tx_brk <= 1'b0;
            after <= ST_DELAY;
            st <= ST_GAP;
          end
        end
        ST_SPLO: begin
          tx_byte <= sp1[7:0];
          after <= ST_DELAY;
          st <= ST_GAP;
        end
        ST_GAP: st <= end_gap ? ST_TX : ST_GAP;
        ST_TX: st <= end_tx ? after : ST_TX;
        ST_BRKHI: begin
          if (end_brk) begin
            tx_brk <= 1'b1;
            after <= ST_RX;
            idx <= 2'd0;
            st <= ST_TX;
          end
        end
        ST_DELAY: begin
          // break in the end delay cancels
          if (rx_done && rx_brk) begin
            st <= ST_BRKHI;
          end else if (end_dly) begin
            idx <= 2'd0;
            st <= ST_RX;
          end
        end
      endcase
    end
  end

  property p_wd_forced;
    @(posedge CLOCK) disable iff (!RST_B) mode.forced |=> WATCHDOG_DISABLE;
  endproperty
  a_wd_forced: assert property (p_wd_forced) else $error("watchdog on in forced mode");

  property p_wd_hv;
    @(posedge CLOCK) disable iff (!RST_B) mode.hv && (hv_irq || hv_rst) |=> WATCHDOG_DISABLE;
  endproperty
  a_wd_hv: assert property (p_wd_hv) else $error("watchdog on under high voltage");

  property p_div4;
    @(posedge CLOCK) disable iff (!RST_B) mode.forced |=> EXT_DIV4;
  endproperty
  a_div4: assert property (p_div4) else $error("forced mode without divide by four");

  property p_vec;
    @(posedge CLOCK) disable iff (!RST_B) mode.monitor |=> VEC_PAGE == MON_PAGE;
  endproperty
  a_vec: assert property (p_vec) else $error("monitor mode on user vector page");

  property p_brk_high;
    @(posedge CLOCK) disable iff (!RST_B) st == ST_BRKHI |=> SERIAL_OE && SERIAL_OUT;
  endproperty
  a_brk_high: assert property (p_brk_high) else $error("pin not high after break");

  property p_gap;
    @(posedge CLOCK) disable iff (!RST_B)
      st == ST_TX && !tx_brk && $past(st) != ST_TX |-> $past(st) == ST_GAP;
  endproperty
  a_gap: assert property (p_gap) else $error("data sent without gap");

  property p_delay;
    @(posedge CLOCK) disable iff (!RST_B)
      $past(st) == ST_DELAY && st == ST_RX |-> $past(nbe) == 4'(END_DELAY_BITS - 1) && $past(tick);
  endproperty
  a_delay: assert property (p_delay) else $error("end delay cut short");

  property p_ready_brk;
    @(posedge CLOCK) disable iff (!RST_B)
      $rose(st == ST_TX && tx_brk) |-> $past(st) == ST_BRKHI || sec_cnt == 4'(SEC_BYTES);
  endproperty
  a_ready_brk: assert property (p_ready_brk) else $error("break before security bytes");

  property p_keep;
    @(posedge CLOCK) disable iff (!POR_RST_B) FLASH_UNLOCKED |=> FLASH_UNLOCKED;
  endproperty
  a_keep: assert property (p_keep) else $error("bypass lost without power-on reset");

  // low byte of pointer plus one
  property p_sp;
    @(posedge CLOCK) disable iff (!RST_B) st == ST_SPLO |=> tx_byte == $past(sp1[7:0]);
  endproperty
  a_sp: assert property (p_sp) else $error("stack read low byte wrong");

endmodule : monitor_serial_command_interface

// ---- verification/mon_host_model.sv ----
/*
  Host programmer model on the single-wire monitor link.
  Assumes the device drive is registered on CLOCK and a pull-up holds the wire high.
*/
`timescale 1ns/1ps
module mon_host_model #(
  parameter int T = 16
) (
  input wire logic CLOCK,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OE,
  output logic host_tx,
  output logic rx_stb,
  output logic [8:0] rx_frame
);
  logic [8:0] f;
  initial begin
    host_tx = 1'b1;
    rx_stb = 1'b0;
    rx_frame = 9'h000;
  end
  task automatic send(input logic [9:0] bits);
    for (int i = 0; i < 10; i++) begin
      host_tx = bits[i];
      repeat (T) @(negedge CLOCK);
    end
    host_tx = 1'b1;
  endtask : send
  // receive at the same bit time
  always begin
    @(negedge CLOCK);
    if (SERIAL_OE && !SERIAL_OUT) begin
      repeat (T / 2) @(negedge CLOCK);
      for (int i = 0; i < 9; i++) begin
        repeat (T) @(negedge CLOCK);
        // Released wire floats to the pull-up level
        f[i] = SERIAL_OE ? SERIAL_OUT : 1'b1;
      end
      rx_frame = f;
      rx_stb = 1'b1;
      @(negedge CLOCK);
      rx_stb = 1'b0;
      while (SERIAL_OE && !SERIAL_OUT) @(negedge CLOCK);
    end
  end
endmodule : mon_host_model

// ---- verification/monitor_serial_command_interface_bench.sv ----
/*
  Self-checking bench of the monitor command block: entry modes, security,
  read and stack commands, break and run. Assumes a flat 64 KB memory model.
*/
`timescale 1ns/1ps
module monitor_serial_command_interface_bench;
  import mon_pkg::*;
  localparam int T = 16;
  localparam logic [7:0] BAD = 8'h3c;
  logic CLOCK, RST_B, POR_RST_B, HV_ON_IRQ, HV_ON_RST, DIVIDER_SELECT_PIN, VECTOR_BLANK;
  logic [15:0] STACK_PTR, sp;
  logic [7:0] MEM_RDATA = 8'h00;
  logic SERIAL_OUT, SERIAL_OE, MEM_VALID, MONITOR_MODE, WATCHDOG_DISABLE, EXT_DIV4;
  logic SWI_ENTRY, RUN_USER, ILLEGAL_RESET, FLASH_UNLOCKED, host_tx, rx_stb;
  logic [7:0] VEC_PAGE;
  logic [8:0] rx_frame;
  mem_req_s MEM;
  logic [7:0] mem [0:65535];
  logic [8:0] exp_q [$];
  int fail_count = 0, cmp_count = 0, cyc = 0, swi_n = 0, run_n = 0, ill_n = 0, s0;
  wire line = SERIAL_OE ? SERIAL_OUT : host_tx;

  monitor_serial_command_interface #(.BIT_CYCLES(T), .FLASH_START(16'hc000), .INVALID_BYTE(BAD))
  u_monitor_serial_command_interface (.CLOCK(CLOCK), .RST_B(RST_B), .POR_RST_B(POR_RST_B),
    .SERIAL_IN(line), .SERIAL_OUT(SERIAL_OUT), .SERIAL_OE(SERIAL_OE), .HV_ON_IRQ(HV_ON_IRQ),
    .HV_ON_RST(HV_ON_RST), .DIVIDER_SELECT_PIN(DIVIDER_SELECT_PIN), .VECTOR_BLANK(VECTOR_BLANK),
    .STACK_PTR(STACK_PTR), .MEM_RDATA(MEM_RDATA), .MEM_VALID(MEM_VALID), .MEM(MEM),
    .MONITOR_MODE(MONITOR_MODE), .WATCHDOG_DISABLE(WATCHDOG_DISABLE), .EXT_DIV4(EXT_DIV4),
    .VEC_PAGE(VEC_PAGE), .SWI_ENTRY(SWI_ENTRY), .RUN_USER(RUN_USER),
    .ILLEGAL_RESET(ILLEGAL_RESET), .FLASH_UNLOCKED(FLASH_UNLOCKED));
  mon_host_model #(.T(T)) u_mon_host_model (.CLOCK(CLOCK), .SERIAL_OUT(SERIAL_OUT),
    .SERIAL_OE(SERIAL_OE), .host_tx(host_tx), .rx_stb(rx_stb), .rx_frame(rx_frame));

  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  // Memory answers one cycle after each request
  always @(posedge CLOCK) begin
    if (MEM_VALID === 1'b1) begin
      if (MEM.we) mem[MEM.addr] <= MEM.wdata;
      MEM_RDATA <= mem[MEM.addr];
    end
  end
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    swi_n <= swi_n + int'(SWI_ENTRY === 1'b1);
    run_n <= run_n + int'(RUN_USER === 1'b1);
    ill_n <= ill_n + int'(ILLEGAL_RESET === 1'b1);
    // Whole run is near 14k cycles
    if (cyc == 90000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chkv(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chkv
  task automatic chkb(input string nm, input logic e, input logic g);
    chkv(nm, {15'h0, e}, {15'h0, g});
  endtask : chkb
  // Every device frame must match the oldest note; break is 9'h000
  always @(posedge rx_stb) begin
    chkv("frame", exp_q.size() > 0 ? {7'h0, exp_q.pop_front()} : 16'hffff, {7'h0, rx_frame});
  end

  task automatic put(input logic [7:0] b);
    exp_q.push_back({1'b1, b});
    u_mon_host_model.send({1'b1, b, 1'b0});
  endtask : put
  task automatic drain(input int gap = 2);
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 40 * T) begin
      @(negedge CLOCK);
      k++;
    end
    chkv("pending", 16'h0, 16'(exp_q.size()));
    repeat (gap * T) @(negedge CLOCK);
  endtask : drain
  task automatic byt(input logic [7:0] b);
    put(b);
    drain();
  endtask : byt
  task automatic rd(input logic [15:0] a, input logic [7:0] d);
    byt(OP_READ);
    byt(a[15:8]);
    put(a[7:0]);
    exp_q.push_back({1'b1, d});
    drain();
    repeat (11 * T) @(negedge CLOCK);
  endtask : rd
  task automatic rst(input logic por, input logic hv, input logic blank);
    @(negedge CLOCK);
    s0 = swi_n;
    RST_B = 1'b0;
    POR_RST_B = !por;
    HV_ON_IRQ = hv;
    VECTOR_BLANK = blank;
    DIVIDER_SELECT_PIN = 1'($urandom);
    repeat (3) @(negedge CLOCK);
    RST_B = 1'b1;
    POR_RST_B = 1'b1;
    repeat (8) @(negedge CLOCK);
    chkb("mode", hv | blank, MONITOR_MODE);
    chkv("page", {8'h0, (hv | blank) ? MON_PAGE : USER_PAGE}, {8'h0, VEC_PAGE});
    chkv("swi", 16'(hv | blank), 16'(swi_n - s0));
    if (hv | blank) begin
      chkb("div4", hv ? DIVIDER_SELECT_PIN : 1'b1, EXT_DIV4);
      chkb("wdog", 1'b1, WATCHDOG_DISABLE);
    end
  endtask : rst
  task automatic sec(input logic ok);
    for (int k = 0; k < SEC_BYTES; k++) begin
      put(mem[SEC_BASE + 16'(k)] ^ ((ok || k != 3) ? 8'h00 : 8'h01));
      if (k == SEC_BYTES - 1) exp_q.push_back(9'h000);
      drain();
    end
    chkb("unlock", ok, FLASH_UNLOCKED);
  endtask : sec
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    void'($urandom(2));
    RST_B = 1'b0;
    POR_RST_B = 1'b0;
    HV_ON_IRQ = 1'b0;
    HV_ON_RST = 1'b0;
    DIVIDER_SELECT_PIN = 1'b0;
    VECTOR_BLANK = 1'b0;
    STACK_PTR = 16'($urandom);
    for (int a = 0; a < 65536; a++) mem[a] = 8'($urandom);
    rst(1'b1, 1'b0, 1'b0);
    rst(1'b1, 1'b1, 1'b0);
    sec(1'b1);
    chkv("flag", {8'h0, SEC_FLAG_MASK}, {8'h0, mem[SEC_FLAG_ADDR]});
    rd(16'hc123, mem[16'hc123]);
    sp = STACK_PTR + 16'h1;
    put(OP_STACK_POINTER_READ_CMD);
    exp_q.push_back({1'b1, sp[15:8]});
    exp_q.push_back({1'b1, sp[7:0]});
    drain(1);
    // Break sent one bit after the low byte is received, inside the end delay
    exp_q.push_back(9'h000);
    u_mon_host_model.send(10'h000);
    drain(2);
    byt(OP_RUN);
    chkv("run", 16'h1, 16'(run_n));
    chkv("illegal", 16'h0, 16'(ill_n));
    // Warm reset, forced entry: bypass kept, no security bytes
    rst(1'b0, 1'b0, 1'b1);
    chkb("keep", 1'b1, FLASH_UNLOCKED);
    for (int i = 0; i < 2; i++) begin
      HV_ON_RST = !HV_ON_RST;
      repeat (6) @(negedge CLOCK);
      chkb("wdog", 1'b1, WATCHDOG_DISABLE);
    end
    rd(16'hfff7, mem[16'hfff7]);
    // Power-on with a wrong code: locked flash
    rst(1'b1, 1'b1, 1'b0);
    HV_ON_RST = 1'b1;
    HV_ON_IRQ = 1'b0;
    repeat (6) @(negedge CLOCK);
    chkb("wdog", 1'b1, WATCHDOG_DISABLE);
    sec(1'b0);
    rd(16'hc010, BAD);
    rd(16'h0080, mem[16'h0080]);
    byt(OP_RUN);
    chkv("illegal", 16'h1, 16'(ill_n));
    finish_test();
  end
endmodule : monitor_serial_command_interface_bench
